// *** design/lmr_pkg.sv ***
// --------
// line monitor shared constants
// --------
package lmr_pkg;

    // register addresses on the serial register port (7-bit)
    localparam logic [6:0] LMR_ADDR_IA_MAG      = 7'h0A;  // phase a current magnitude
    localparam logic [6:0] LMR_ADDR_IB_MAG      = 7'h0B;  // phase b current magnitude
    localparam logic [6:0] LMR_ADDR_IC_MAG      = 7'h0C;  // phase c current magnitude
    localparam logic [6:0] LMR_ADDR_VA_MAG      = 7'h0D;  // phase a voltage magnitude
    localparam logic [6:0] LMR_ADDR_VB_MAG      = 7'h0E;  // phase b voltage magnitude
    localparam logic [6:0] LMR_ADDR_VC_MAG      = 7'h0F;  // phase c voltage magnitude
    localparam logic [6:0] LMR_ADDR_THERMAL     = 7'h11;  // thermal code
    localparam logic [6:0] LMR_ADDR_MODE        = 7'h14;  // measurement mode register
    localparam logic [6:0] LMR_ADDR_OV_THR      = 7'h16;  // overvoltage threshold
    localparam logic [6:0] LMR_ADDR_IRQ_MASK    = 7'h18;  // interrupt mask
    localparam logic [6:0] LMR_ADDR_IRQ_STATUS  = 7'h19;  // interrupt status, write one to clear
    localparam logic [6:0] LMR_ADDR_RMS_CTRL    = 7'h1A;  // rms control
    localparam logic [6:0] LMR_ADDR_SUPPLY      = 7'h1B;  // supply state

    // field positions
    localparam int LMR_MODE_OVSEL_LSB  = 5;   // overvoltage phase select, bits 7:5
    localparam int LMR_STAT_OV_BIT     = 14;  // overvoltage flag
    localparam int LMR_STAT_SEQ_BIT    = 19;  // phase order error flag
    localparam int LMR_CTRL_INTEG_BIT  = 0;   // integrator on
    localparam int LMR_SMP_WIN_LSB     = 6;   // compared sample window, bits 13:6

    // reset values
    localparam logic [7:0]  LMR_MODE_RST    = 8'h00;
    localparam logic [7:0]  LMR_OV_THR_RST  = 8'hFF;
    localparam logic [23:0] LMR_MASK_RST    = 24'h000000;
    localparam logic [7:0]  LMR_CTRL_RST    = 8'h00;

    // timing
    localparam int LMR_CLK_HZ          = 20_000_000;
    localparam int LMR_TEMP_PERIOD_CYC = 4;   // new temperature every 4 clocks
    localparam int LMR_RMS_DIV         = 12;  // rms refresh at clock / 12
    localparam int LMR_SUP_FALL_US     = 10;  // supply low must persist this long
    localparam int LMR_SUP_RISE_US     = 100; // supply good must persist this long
    localparam int LMR_SUP_FALL_CYC    = (LMR_SUP_FALL_US * LMR_CLK_HZ) / 1_000_000;
    localparam int LMR_SUP_RISE_CYC    = (LMR_SUP_RISE_US * LMR_CLK_HZ) / 1_000_000;

    // low-pass shifts: larger shift, narrower band, slower settling
    localparam logic [3:0] LMR_LPF_SHIFT_VOLT   = 4'hD;
    localparam logic [3:0] LMR_LPF_SHIFT_CUR    = 4'hC;
    localparam logic [3:0] LMR_LPF_SHIFT_CUR_IN = 4'hB;

endpackage

// *** design/lmr_rms_engine.sv ***
`timescale 1ns/100ps
// square, low-pass and square root for one channel
module lmr_rms_engine (
    input  wire logic               clk_sys,    // system clock
    input  wire logic               rst,        // async reset
    input  wire logic               smp_vld,    // new sample strobe
    input  wire logic signed [23:0] smp,        // signed sample
    input  wire logic [3:0]         lpf_shift,  // filter coefficient as shift
    input  wire logic               refresh,    // start of a refresh period
    output logic [23:0]             rms_r       // unsigned magnitude
);
    import lmr_pkg::*;

    logic [47:0] acc_r;   // filtered square
    logic [47:0] rad_r;   // radicand being consumed
    logic [25:0] rem_r;   // root remainder
    logic [23:0] root_r;  // partial root
    logic [3:0]  cnt_r;   // iteration pair counter
    logic        busy_r;  // root in progress

    // one restoring square root step, two radicand bits
    function automatic logic [49:0] sqrt_step(input logic [25:0] rem, input logic [23:0] root,
                                              input logic [1:0] bits);
        logic [27:0] r;
        logic [27:0] trial;
        r     = {rem, bits};
        trial = {2'b00, root, 2'b01};
        if (r >= trial) begin
            sqrt_step = {r[25:0] - trial[25:0], root[22:0], 1'b1};
        end else begin
            sqrt_step = {r[25:0], root[22:0], 1'b0};
        end
    endfunction

    // --------
    // square and first order low-pass
    // --------
    logic signed [47:0] sq;
    logic signed [48:0] diff;
    logic signed [48:0] step;
    always_comb begin
        sq   = smp * smp;
        diff = $signed({1'b0, sq}) - $signed({1'b0, acc_r});
        step = diff >>> lpf_shift;
    end

    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            acc_r <= 48'h0;
        end else if (smp_vld) begin
            acc_r <= acc_r + step[47:0];
        end
    end

    // --------
    // square root, two bits per clock, done within 12 clocks
    // --------
    logic [49:0] s1;
    logic [49:0] s2;
    always_comb begin
        s1 = sqrt_step(rem_r, root_r, rad_r[47:46]);
        s2 = sqrt_step(s1[49:24], s1[23:0], rad_r[45:44]);
    end

    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            rad_r  <= 48'h0;
            rem_r  <= 26'h0;
            root_r <= 24'h0;
            cnt_r  <= 4'h0;
            busy_r <= 1'b0;
            rms_r  <= 24'h0;
        end else if (refresh) begin
            // last root step shares the next refresh edge
            if (busy_r && (cnt_r == 4'(LMR_RMS_DIV - 1))) begin
                rms_r <= s2[23:0];
            end
            // snapshot so the filter may keep running meanwhile
            rad_r  <= acc_r;
            rem_r  <= 26'h0;
            root_r <= 24'h0;
            cnt_r  <= 4'h0;
            busy_r <= 1'b1;
        end else if (busy_r) begin
            rad_r  <= {rad_r[43:0], 4'h0};
            rem_r  <= s2[49:24];
            root_r <= s2[23:0];
            cnt_r  <= cnt_r + 4'h1;
        end
    end

endmodule // lmr_rms_engine

// *** design/lmr_line_monitor.sv ***
`timescale 1ns/100ps
//
// Functional notes
// - threshold meets sample bits 13:6, 0x9D full-scale
// - sample above threshold sets status bit 14
// - enabled overvoltage flag pulls interrupt low
// - any enabled phase sets the single flag
// - mode bits 7:5 choose monitored phases
// - B after A crossing sets bit 19
// - enabled sequence flag pulls interrupt low
// - low supply stops all energy accumulation
// - supply indication filtered with hysteresis
// - temperature taken every four clocks, address 0x11
// - temperature code signed, three degrees per step
// - rms is square, low-pass, square root
// - six channels computed together, separate registers
// - voltage band 260 Hz, current 14 kHz
// - current rms uses waveform-mode current samples
// - current magnitude unsigned 24-bit, sample-weighted
// - current magnitude refreshed at clock over twelve
// - full-scale 60 Hz current reads near 0x1D3781
// - current settling depends on integrator setting
//
module lmr_line_monitor (
    input  wire logic               clk_sys,        // master clock
    input  wire logic               rst,            // async reset, active high
    // register port
    input  wire logic [6:0]         reg_addr,       // register address
    input  wire logic               reg_wr,         // write strobe
    input  wire logic [23:0]        reg_wdata,      // write data, low byte used by 8-bit registers
    input  wire logic               reg_rd,         // read strobe
    output logic [23:0]             reg_rdata_r,    // read data, one clock after strobe
    // waveform samples
    input  wire logic [2:0]         volt_vld,       // voltage sample strobes, bit0 = a
    input  wire logic signed [15:0] volt_smp_a,     // phase a voltage sample
    input  wire logic signed [15:0] volt_smp_b,     // phase b voltage sample
    input  wire logic signed [15:0] volt_smp_c,     // phase c voltage sample
    input  wire logic [2:0]         cur_vld,        // current sample strobes, bit0 = a
    input  wire logic signed [23:0] cur_smp_a,      // phase a current waveform sample
    input  wire logic signed [23:0] cur_smp_b,      // phase b current waveform sample
    input  wire logic signed [23:0] cur_smp_c,      // phase c current waveform sample
    input  wire logic [2:0]         zero_cross,     // voltage zero crossing pulses, bit0 = a
    // sensors
    input  wire logic               supply_low_in,  // supply comparator, asynchronous
    input  wire logic [7:0]         temp_adc,       // temperature converter code
    // outputs
    output logic                    irq_n_r,        // interrupt request, active low
    output logic                    accum_en_r      // energy accumulation allowed
);
    import lmr_pkg::*;

    // --------
    // helpers
    // --------
    // absolute value, saturating the most negative code
    function automatic logic [15:0] abs16(input logic signed [15:0] v);
        if (v == 16'sh8000) begin
            abs16 = 16'h7FFF;
        end else if (v < 0) begin
            abs16 = 16'(-v);
        end else begin
            abs16 = 16'(v);
        end
    endfunction

    // overvoltage test on one sample window
    function automatic logic over_thr(input logic signed [15:0] v, input logic [7:0] thr);
        logic [15:0] a;
        a        = abs16(v);
        over_thr = a[LMR_SMP_WIN_LSB +: 8] > thr;
    endfunction

    // --------
    // software registers
    // --------
    logic [7:0]  mode_r;      // measurement mode register
    logic [7:0]  ov_thr_r;    // overvoltage threshold
    logic [23:0] mask_r;      // interrupt mask
    logic [7:0]  ctrl_r;      // rms control
    logic [23:0] status_r;    // interrupt status
    logic [7:0]  thermal_r;   // thermal code
    logic        inactive_r;  // filtered supply low state

    logic        wr_mode;
    logic        wr_thr;
    logic        wr_mask;
    logic        wr_ctrl;
    logic        wr_stat;
    always_comb begin
        wr_mode = reg_wr && (reg_addr == LMR_ADDR_MODE);
        wr_thr  = reg_wr && (reg_addr == LMR_ADDR_OV_THR);
        wr_mask = reg_wr && (reg_addr == LMR_ADDR_IRQ_MASK);
        wr_ctrl = reg_wr && (reg_addr == LMR_ADDR_RMS_CTRL);
        wr_stat = reg_wr && (reg_addr == LMR_ADDR_IRQ_STATUS);
    end

    // control register writes
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            mode_r   <= LMR_MODE_RST;
            ov_thr_r <= LMR_OV_THR_RST;
            mask_r   <= LMR_MASK_RST;
            ctrl_r   <= LMR_CTRL_RST;
        end else begin
            if (wr_mode) begin
                mode_r <= reg_wdata[7:0];
            end
            if (wr_thr) begin
                ov_thr_r <= reg_wdata[7:0];
            end
            if (wr_mask) begin
                mask_r <= reg_wdata;
            end
            if (wr_ctrl) begin
                ctrl_r <= reg_wdata[7:0];
            end
        end
    end

    // --------
    // overvoltage detection
    // --------
    logic [2:0] ov_sel;   // phases monitored
    logic [2:0] ov_hit;   // per phase hit this clock
    logic       ov_evt;   // any monitored phase over
    always_comb begin
        ov_sel    = mode_r[LMR_MODE_OVSEL_LSB +: 3];
        // only a fresh sample is judged, so a held bus cannot retrigger
        ov_hit[0] = volt_vld[0] && ov_sel[0] && over_thr(volt_smp_a, ov_thr_r);
        ov_hit[1] = volt_vld[1] && ov_sel[1] && over_thr(volt_smp_b, ov_thr_r);
        ov_hit[2] = volt_vld[2] && ov_sel[2] && over_thr(volt_smp_c, ov_thr_r);
        ov_evt    = |ov_hit;
    end

    // --------
    // phase order detection
    // --------
    logic armed_r;   // last crossing seen was phase a
    logic seq_evt;   // b came right after a
    always_comb begin
        // b and c together after a: c is taken as the follower, no error
        seq_evt = armed_r && zero_cross[1] && !zero_cross[2];
    end

    // track which phase crossed most recently
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            armed_r <= 1'b0;
        end else if (zero_cross[0]) begin
            armed_r <= 1'b1;
        end else if (zero_cross[1] || zero_cross[2]) begin
            armed_r <= 1'b0;
        end
    end

    // --------
    // interrupt status, write one to clear, hardware set wins
    // --------
    logic [23:0] stat_set;
    logic [23:0] stat_clr;
    always_comb begin
        stat_set                   = 24'h000000;
        stat_set[LMR_STAT_OV_BIT]  = ov_evt;
        stat_set[LMR_STAT_SEQ_BIT] = seq_evt;
        stat_clr                   = wr_stat ? reg_wdata : 24'h000000;
    end

    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            status_r <= 24'h000000;
        end else begin
            status_r <= (status_r & ~stat_clr) | stat_set;
        end
    end

    // interrupt line follows status and mask, one clock later
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            irq_n_r <= 1'b1;
        end else begin
            irq_n_r <= ~|(status_r & mask_r);
        end
    end

    // --------
    // supply monitor: three stage sync, then filtered hysteresis
    // --------
    logic        sup_s1_r;  // first sync stage
    logic        sup_s2_r;  // second sync stage
    logic        sup_s3_r;  // third sync stage
    logic [11:0] sup_cnt_r; // persistence counter
    logic        sup_stable;
    logic        sup_seen;
    always_comb begin
        sup_stable = (sup_s2_r == sup_s3_r);
        sup_seen   = sup_s3_r;
    end

    // synchroniser chain
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            sup_s1_r <= 1'b0;
            sup_s2_r <= 1'b0;
            sup_s3_r <= 1'b0;
        end else begin
            sup_s1_r <= supply_low_in;
            sup_s2_r <= sup_s1_r;
            sup_s3_r <= sup_s2_r;
        end
    end

    // a level must hold for the whole filter time before the state flips;
    // the longer release time gives the hysteresis against a ripply supply
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            sup_cnt_r  <= 12'h000;
            inactive_r <= 1'b1;
        end else if (!sup_stable || (sup_seen == inactive_r)) begin
            sup_cnt_r <= 12'h000;
        end else if (!inactive_r && (sup_cnt_r == 12'(LMR_SUP_FALL_CYC - 1))) begin
            sup_cnt_r  <= 12'h000;
            inactive_r <= 1'b1;
        end else if (inactive_r && (sup_cnt_r == 12'(LMR_SUP_RISE_CYC - 1))) begin
            sup_cnt_r  <= 12'h000;
            inactive_r <= 1'b0;
        end else begin
            sup_cnt_r <= sup_cnt_r + 12'h001;
        end
    end

    // accumulation gate for the energy path
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            accum_en_r <= 1'b0;
        end else begin
            accum_en_r <= ~inactive_r;
        end
    end

    // --------
    // temperature capture
    // --------
    logic [1:0] temp_cnt_r;  // four clock measurement period
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            temp_cnt_r <= 2'h0;
            thermal_r  <= 8'h00;
        end else begin
            temp_cnt_r <= temp_cnt_r + 2'h1;
            if (temp_cnt_r == 2'(LMR_TEMP_PERIOD_CYC - 1)) begin
                // code kept as signed twos complement, 3 degC per step;
                // offset trimming is left to the host
                thermal_r <= temp_adc;
            end
        end
    end

    // --------
    // rms engines
    // --------
    logic [3:0] rms_cnt_r;   // refresh divider
    logic       refresh;     // one clock in twelve
    logic [3:0] cur_shift;   // current filter coefficient
    always_comb begin
        refresh   = (rms_cnt_r == 4'h0);
        // integrator on trades settling ripple for a faster first response
        cur_shift = ctrl_r[LMR_CTRL_INTEG_BIT] ? LMR_LPF_SHIFT_CUR_IN : LMR_LPF_SHIFT_CUR;
    end

    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            rms_cnt_r <= 4'h0;
        end else if (rms_cnt_r == 4'(LMR_RMS_DIV - 1)) begin
            rms_cnt_r <= 4'h0;
        end else begin
            rms_cnt_r <= rms_cnt_r + 4'h1;
        end
    end

    logic [23:0]        cur_mag [3];   // current magnitudes
    logic [23:0]        volt_mag [3];  // voltage magnitudes
    logic signed [23:0] cur_in [3];    // current engine inputs
    logic signed [23:0] volt_in [3];   // voltage inputs scaled by 256
    always_comb begin
        // current engines read the waveform samples directly, so one
        // magnitude step equals one sample step
        cur_in[0]  = cur_smp_a;
        cur_in[1]  = cur_smp_b;
        cur_in[2]  = cur_smp_c;
        volt_in[0] = {volt_smp_a, 8'h00};
        volt_in[1] = {volt_smp_b, 8'h00};
        volt_in[2] = {volt_smp_c, 8'h00};
    end

    // six engines run side by side on a shared refresh
    genvar g;
    for (g = 0; g < 3; g++) begin : g_ph
        lmr_rms_engine u_cur (
            .clk_sys   (clk_sys),
            .rst       (rst),
            .smp_vld   (cur_vld[g]),
            .smp       (cur_in[g]),
            .lpf_shift (cur_shift),
            .refresh   (refresh),
            .rms_r     (cur_mag[g])
        );
        lmr_rms_engine u_volt (
            .clk_sys   (clk_sys),
            .rst       (rst),
            .smp_vld   (volt_vld[g]),
            .smp       (volt_in[g]),
            .lpf_shift (LMR_LPF_SHIFT_VOLT),
            .refresh   (refresh),
            .rms_r     (volt_mag[g])
        );
    end

    // --------
    // read path, unmapped addresses read zero
    // --------
    logic [23:0] rd_mux;
    always_comb begin
        case (reg_addr)
            LMR_ADDR_IA_MAG:     rd_mux = cur_mag[0];
            LMR_ADDR_IB_MAG:     rd_mux = cur_mag[1];
            LMR_ADDR_IC_MAG:     rd_mux = cur_mag[2];
            LMR_ADDR_VA_MAG:     rd_mux = volt_mag[0];
            LMR_ADDR_VB_MAG:     rd_mux = volt_mag[1];
            LMR_ADDR_VC_MAG:     rd_mux = volt_mag[2];
            LMR_ADDR_THERMAL:    rd_mux = {16'h0000, thermal_r};
            LMR_ADDR_MODE:       rd_mux = {16'h0000, mode_r};
            LMR_ADDR_OV_THR:     rd_mux = {16'h0000, ov_thr_r};
            LMR_ADDR_IRQ_MASK:   rd_mux = mask_r;
            LMR_ADDR_IRQ_STATUS: rd_mux = status_r;
            LMR_ADDR_RMS_CTRL:   rd_mux = {16'h0000, ctrl_r};
            LMR_ADDR_SUPPLY:     rd_mux = {23'h0, inactive_r};
            default:             rd_mux = 24'h000000;
        endcase
    end

    // read data is captured on the strobe and held until the next one
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            reg_rdata_r <= 24'h000000;
        end else if (reg_rd) begin
            reg_rdata_r <= rd_mux;
        end
    end

endmodule // lmr_line_monitor

// *** testbench/lmr_line_monitor_properties.sv ***
`timescale 1ns/100ps
// --------
// port-level checks of the line monitor
// --------
module lmr_line_monitor_chk (
    input wire logic               clk_sys,
    input wire logic               rst,
    input wire logic [6:0]         reg_addr,
    input wire logic               reg_wr,
    input wire logic [23:0]        reg_wdata,
    input wire logic               reg_rd,
    input wire logic [23:0]        reg_rdata_r,
    input wire logic [2:0]         volt_vld,
    input wire logic signed [15:0] volt_smp_a,
    input wire logic signed [15:0] volt_smp_b,
    input wire logic signed [15:0] volt_smp_c,
    input wire logic [2:0]         zero_cross,
    input wire logic               supply_low_in,
    input wire logic               irq_n_r,
    input wire logic               accum_en_r
);
    import lmr_pkg::*;
    logic [23:0] mask_r;   // mirror of the interrupt mask
    logic [7:0]  mode_r;   // mirror of the mode register
    logic [7:0]  thr_r;    // mirror of the threshold
    logic [7:0]  lo_r;     // cycles of supply low, saturating
    logic [11:0] hi_r;     // cycles of supply good, saturating
    logic        armed_r;  // last crossing was phase a
    logic        ov_hit;   // some selected sample above threshold
    logic        seq_hit;  // b crossing right after a
    // mirrors of host writes
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            mask_r <= LMR_MASK_RST;
            mode_r <= LMR_MODE_RST;
            thr_r  <= LMR_OV_THR_RST;
        end else if (reg_wr) begin
            if (reg_addr == LMR_ADDR_IRQ_MASK) mask_r <= reg_wdata;
            if (reg_addr == LMR_ADDR_MODE) mode_r <= reg_wdata[7:0];
            if (reg_addr == LMR_ADDR_OV_THR) thr_r <= reg_wdata[7:0];
        end
    end
    // supply counters and crossing order tracker
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            lo_r    <= 8'h00;
            hi_r    <= 12'h000;
            armed_r <= 1'b0;
        end else begin
            lo_r    <= !supply_low_in ? 8'h00 : (lo_r == 8'hFF ? lo_r : lo_r + 8'h01);
            hi_r    <= supply_low_in ? 12'h000 : (hi_r == 12'hFFF ? hi_r : hi_r + 12'h001);
            armed_r <= zero_cross[0] ? 1'b1 : (|zero_cross ? 1'b0 : armed_r);
        end
    end
    // most negative code saturates
    function automatic logic [7:0] win(input logic signed [15:0] s);
        logic [15:0] a;
        a = (s == 16'sh8000) ? 16'h7FFF : (s[15] ? -s : s);
        return a[13:6];
    endfunction
    assign ov_hit  = |(volt_vld & mode_r[7:5] & {win(volt_smp_c) > thr_r, win(volt_smp_b) > thr_r,
                       win(volt_smp_a) > thr_r});
    assign seq_hit = armed_r && zero_cross == 3'b010;
    default clocking @(posedge clk_sys); endclocking
    default disable iff (rst);
    read_hold_a: assert property (!reg_rd |=> $stable(reg_rdata_r))
        else $error("read data moved");
    mode_read_a: assert property (reg_rd && reg_addr == LMR_ADDR_MODE |=> reg_rdata_r == {16'h0, $past(mode_r)})
        else $error("mode read mismatch");
    supply_fall_a: assert property (lo_r == 8'hDC |-> !accum_en_r)
        else $error("kept on when low");
    supply_filter_a: assert property ($fell(accum_en_r) |-> lo_r >= 8'hC8)
        else $error("stopped too soon");
    supply_rise_a: assert property ($rose(accum_en_r) |-> hi_r >= 12'h7D0)
        else $error("resumed too soon");
    irq_masked_a: assert property (mask_r == 24'h0 && $past(mask_r) == 24'h0 |-> irq_n_r)
        else $error("masked interrupt");
    ov_irq_a: assert property (ov_hit && mask_r[14] |-> ##2 !irq_n_r)
        else $error("overvoltage missed");
    seq_irq_a: assert property (seq_hit && mask_r[19] |-> ##2 !irq_n_r)
        else $error("order error missed");
endmodule // lmr_line_monitor_chk

bind lmr_line_monitor lmr_line_monitor_chk u_lmr_line_monitor_chk (.*);

// *** testbench/lmr_host_model.sv ***
`timescale 1ns/100ps
// --------
// host side of the register port
// --------
module lmr_host_model (
    input wire logic        clk_sys,
    output logic [6:0]      reg_addr,
    output logic            reg_wr,
    output logic [23:0]     reg_wdata,
    output logic            reg_rd,
    input wire logic [23:0] reg_rdata_r
);
    initial begin
        reg_addr  = 7'h00;
        reg_wr    = 1'b0;
        reg_wdata = 24'h0;
        reg_rd    = 1'b0;
    end
    // one-cycle strobe; idle bus shows inverted junk, never stale data
    task acc(input logic w, input logic [6:0] a, input logic [23:0] v);
        @(posedge clk_sys);
        #1;
        reg_addr  = a;
        reg_wdata = v;
        reg_wr    = w;
        reg_rd    = !w;
        @(posedge clk_sys);
        #1;
        reg_wr    = 1'b0;
        reg_rd    = 1'b0;
        reg_addr  = ~a;
        reg_wdata = ~v;
    endtask
    task wr(input logic [6:0] a, input logic [23:0] v);
        acc(1'b1, a, v);
    endtask
    task rd(input logic [6:0] a, output logic [23:0] d);
        acc(1'b0, a, 24'h0);
        d = reg_rdata_r;
    endtask
endmodule // lmr_host_model

// *** testbench/lmr_line_monitor_test.sv ***
`timescale 1ns/100ps
module lmr_line_monitor_test;
    import lmr_pkg::*;
    // --------
    // stimulus and design
    // --------
    logic clk_sys = 0, rst = 1, reg_wr, reg_rd, supply_low_in = 0, irq_n_r, accum_en_r;
    logic [6:0] reg_addr;
    logic [23:0] reg_wdata, reg_rdata_r, d;
    logic [2:0] volt_vld = 0, cur_vld = 0, zc = 0;
    logic signed [15:0] vs_smp = 0;
    logic signed [23:0] ia = 0, ib = 0;
    logic [7:0] temp_adc = 8'hE5;
    int bad_count = 0, total_checks = 0;
    always #25 clk_sys = ~clk_sys;
    lmr_line_monitor u_lmr_line_monitor (.clk_sys, .rst, .reg_addr, .reg_wr, .reg_wdata, .reg_rd,
        .reg_rdata_r, .volt_vld, .volt_smp_a(vs_smp), .volt_smp_b(vs_smp), .volt_smp_c(vs_smp),
        .cur_vld, .cur_smp_a(ia), .cur_smp_b(ib), .cur_smp_c(24'sh0), .zero_cross(zc),
        .supply_low_in, .temp_adc, .irq_n_r, .accum_en_r);
    lmr_host_model u_lmr_host_model (.clk_sys, .reg_addr, .reg_wr, .reg_wdata, .reg_rd, .reg_rdata_r);
    task cyc(input int n);
        repeat (n) @(posedge clk_sys);
        #1;
    endtask
    task chk(input logic ok, input string m);
        total_checks++;
        if (ok !== 1'b1) begin
            bad_count++;
            $display("[FAIL] %0t %s", $time, m);
        end
    endtask
    task summarize;
        $display("checks %0d mismatches %0d", total_checks, bad_count);
        if (bad_count == 0 && total_checks > 0) $display("All tests passed");
        else $display("Some tests failed");
        $finish;
    endtask
    // bounded wait; running out ends the run as a mismatch
    task wait_acc(input logic v);
        for (int i = 0; i < 3000 && accum_en_r !== v; i++) cyc(1);
        chk(accum_en_r === v, "wait ran out");
        if (accum_en_r !== v) summarize();
    endtask
    task pulse(input logic [2:0] m, input logic volt);
        if (volt) volt_vld = m;
        else zc = m;
        cyc(1);
        volt_vld = 3'b000;
        zc = 3'b000;
        cyc(2);
    endtask
    task t_supply;
        wait_acc(1'b1);
        supply_low_in = 1'b1;
        cyc(50);
        supply_low_in = 1'b0;
        cyc(10);
        chk(accum_en_r === 1'b1, "glitch toggled state");
        supply_low_in = 1'b1;
        cyc(240);
        chk(accum_en_r === 1'b0, "still accumulating");
        supply_low_in = 1'b0;
        wait_acc(1'b1);
        $display("supply test done");
    endtask
    task t_ov;
        u_lmr_host_model.wr(LMR_ADDR_OV_THR, 24'h9D);
        u_lmr_host_model.wr(LMR_ADDR_MODE, 24'h40);
        u_lmr_host_model.wr(LMR_ADDR_IRQ_MASK, 24'h004000);
        u_lmr_host_model.rd(LMR_ADDR_MODE, d);
        chk(d === 24'h000040, "mode readback");
        vs_smp = 16'sh7FFF;
        pulse(3'b001, 1'b1);
        chk(irq_n_r === 1'b1, "unselected phase tripped");
        vs_smp = -16'sh2740;
        pulse(3'b010, 1'b1);
        chk(irq_n_r === 1'b1, "equal level tripped");
        vs_smp = -16'sh2780;
        pulse(3'b010, 1'b1);
        chk(irq_n_r === 1'b0, "overvoltage missed");
        u_lmr_host_model.rd(LMR_ADDR_IRQ_STATUS, d);
        chk(d[14] === 1'b1 && d[19] === 1'b0, "status after overvoltage");
        u_lmr_host_model.wr(LMR_ADDR_IRQ_STATUS, 24'h004000);
        cyc(2);
        chk(irq_n_r === 1'b1, "flag not cleared");
        $display("overvoltage test done");
    endtask
    task t_seq;
        u_lmr_host_model.wr(LMR_ADDR_IRQ_MASK, 24'h080000);
        pulse(3'b010, 1'b0);
        pulse(3'b001, 1'b0);
        pulse(3'b100, 1'b0);
        chk(irq_n_r === 1'b1, "good order flagged");
        pulse(3'b001, 1'b0);
        pulse(3'b010, 1'b0);
        chk(irq_n_r === 1'b0, "bad order missed");
        u_lmr_host_model.rd(LMR_ADDR_IRQ_STATUS, d);
        chk(d[19] === 1'b1, "order flag not held");
        $display("phase order test done");
    endtask
    task t_temp_rms;
        ia = 24'sd1914753;
        ib = -24'sd1914753;
        cur_vld = 3'b111;
        u_lmr_host_model.wr(LMR_ADDR_THERMAL, 24'h0);
        u_lmr_host_model.rd(LMR_ADDR_THERMAL, d);
        chk(d[7:0] === 8'hE5, "thermal code");
        u_lmr_host_model.rd(7'h7F, d);
        chk(d === 24'h0, "unmapped read");
        cyc(40000);
        u_lmr_host_model.rd(LMR_ADDR_IA_MAG, d);
        chk(d > 24'h1CC281 && d < 24'h1DAC81, "phase a magnitude");
        u_lmr_host_model.rd(LMR_ADDR_IB_MAG, d);
        chk(d > 24'h1CC281 && d < 24'h1DAC81, "phase b magnitude");
        u_lmr_host_model.rd(LMR_ADDR_IC_MAG, d);
        chk(d === 24'h0, "phase c magnitude");
        $display("rms test done");
    endtask
    initial begin
        cyc(6);
        rst = 1'b0;
        t_supply();
        t_ov();
        t_seq();
        t_temp_rms();
        summarize();
    end
endmodule // lmr_line_monitor_test
